// ### common/uartx_consts.svh
// Named constants of the transmit control block
`ifndef UARTX_CONSTS_SVH
`define UARTX_CONSTS_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define UX_CLK_PERIOD_NS 4
`define UX_TC_SETUP_NS 225
`define UX_TC_CYCLES \
   ((`UX_TC_SETUP_NS + `UX_CLK_PERIOD_NS - 1) / `UX_CLK_PERIOD_NS)
// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define UX_B_STOP 2
`define UX_B_LEN_LO 3
`define UX_B_LEN_HI 4
`define UX_B_BREAK 6
`define UX_B_SEND 7
`define UX_CTRL_RST 8'h00
// ----------------------------------------------------------------
// Framing, counted in device clocks
// ----------------------------------------------------------------
`define UX_CLKS_BIT_LAST 6'h0F
`define UX_STOP_ONE 6'h10
`define UX_STOP_ONEHALF 6'h18
`define UX_STOP_TWO 6'h20
`define UX_LAST_BASE 3'h4
// ----------------------------------------------------------------
// Positions in the synchronised pin vector
// ----------------------------------------------------------------
`define UX_P_W 16
`define UX_P_TPB 15
`define UX_P_CSA 14
`define UX_P_CSN 13
`define UX_P_CSB 12
`define UX_P_RDWR 11
`define UX_P_RSEL 10
`define UX_P_CTSN 9
`define UX_P_MCLRN 8
`endif

// ### common/uartx_pkg.sv
// Types shared by the transmit control block
package uartx_pkg;
   // Shifter states, one-hot
   typedef enum logic [4:0] {
      ux_sh_idle = 5'h01,
      ux_sh_armed = 5'h02,
      ux_sh_start = 5'h04,
      ux_sh_data = 5'h08,
      ux_sh_stop = 5'h10
   } uartx_sh_t;

   typedef struct packed {
      uartx_sh_t st;
      logic [5:0] clk_cnt;
      logic [2:0] bit_idx;
      logic [7:0] sreg;
      logic [1:0] len;
      logic stop_sel;
      logic line;
      logic done;
   } uartx_shift_st_t;

   typedef struct packed {
      logic [15:0] s1;
      logic [15:0] s2;
      logic [15:0] s3;
      logic [15:0] pins;
      logic tpb_prev;
      logic cts_prev;
      logic qual_ok;
      logic [7:0] wdata;
      logic wsel;
      logic [7:0] ctrl;
      logic [7:0] hold;
      logic hold_full;
      logic [15:0] wait_cnt;
      logic [15:0] div_cnt;
      logic rise;
      logic fall;
      logic load;
      logic serial;
      logic rts_n;
      logic holding_empty_flag;
   } uartx_top_st_t;
endpackage : uartx_pkg

// ### common/uartx_link_if.sv
// Link between transmit control and the serialiser
`timescale 1ns/10ps
`default_nettype none
interface uartx_link_if;
   logic load;
   logic rise_tick;
   logic abort;
   logic stop_sel;
   logic [1:0] len_sel;
   logic [7:0] data;
   logic line;
   logic busy;
   logic done;

   modport ctrl (
      output load, rise_tick, abort, stop_sel, len_sel, data,
      input line, busy, done
   );
   modport shift (
      input load, rise_tick, abort, stop_sel, len_sel, data,
      output line, busy, done
   );
endinterface : uartx_link_if
`default_nettype wire

// ### verilog/uartx_shift.sv
// Transmit shift register and character framing
`timescale 1ns/10ps
`default_nettype none
`include "uartx_consts.svh"
module uartx_shift
   import uartx_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   uartx_link_if.shift lk
);
   localparam uartx_shift_st_t SH_RST = '{
      st: ux_sh_idle, clk_cnt: 6'h00, bit_idx: 3'h0, sreg: 8'h00,
      len: 2'h0, stop_sel: 1'b0, line: 1'b1, done: 1'b0};

   uartx_shift_st_t st_ff;
   uartx_shift_st_t nxt_st;
   logic [2:0] last_idx;
   logic [5:0] stop_clks;

   // ----------------------------------------------------------------
   // Framing lengths
   // ----------------------------------------------------------------
   // Last data index and stop duration from the latched selection
   always_comb
   begin
      last_idx = `UX_LAST_BASE + {1'b0, st_ff.len};
      if (!st_ff.stop_sel)
         stop_clks = `UX_STOP_ONE;
      else if (st_ff.len == 2'h0)
         stop_clks = `UX_STOP_ONEHALF;
      else
         stop_clks = `UX_STOP_TWO;
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // All counting is on rising device-clock ticks
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      if (lk.abort)
      begin
         nxt_st.st = ux_sh_idle;
         nxt_st.line = 1'b1;
      end
      else
      begin
         unique case (st_ff.st)
            ux_sh_idle:
               if (lk.load)
               begin
                  nxt_st.st = ux_sh_armed;
                  nxt_st.sreg = lk.data;
                  nxt_st.len = lk.len_sel;
                  nxt_st.stop_sel = lk.stop_sel;
               end
            ux_sh_armed:
               // Loaded on a falling edge, start half a period later
               if (lk.rise_tick)
               begin
                  nxt_st.st = ux_sh_start;
                  nxt_st.line = 1'b0;
                  nxt_st.clk_cnt = 6'h00;
               end
            ux_sh_start:
               if (lk.rise_tick)
               begin
                  if (st_ff.clk_cnt == `UX_CLKS_BIT_LAST)
                  begin
                     nxt_st.st = ux_sh_data;
                     nxt_st.line = st_ff.sreg[0];
                     nxt_st.sreg = {1'b0, st_ff.sreg[7:1]};
                     nxt_st.bit_idx = 3'h0;
                     nxt_st.clk_cnt = 6'h00;
                  end
                  else
                     nxt_st.clk_cnt = st_ff.clk_cnt + 6'h01;
               end
            ux_sh_data:
               if (lk.rise_tick)
               begin
                  if (st_ff.clk_cnt != `UX_CLKS_BIT_LAST)
                     nxt_st.clk_cnt = st_ff.clk_cnt + 6'h01;
                  else if (st_ff.bit_idx == last_idx)
                  begin
                     nxt_st.st = ux_sh_stop;
                     nxt_st.line = 1'b1;
                     nxt_st.clk_cnt = 6'h00;
                  end
                  else
                  begin
                     nxt_st.bit_idx = st_ff.bit_idx + 3'h1;
                     nxt_st.line = st_ff.sreg[0];
                     nxt_st.sreg = {1'b0, st_ff.sreg[7:1]};
                     nxt_st.clk_cnt = 6'h00;
                  end
               end
            ux_sh_stop:
               if (lk.rise_tick)
               begin
                  if (st_ff.clk_cnt + 6'h01 == stop_clks)
                  begin
                     nxt_st.st = ux_sh_idle;
                     nxt_st.done = 1'b1;
                  end
                  else
                     nxt_st.clk_cnt = st_ff.clk_cnt + 6'h01;
               end
         endcase
      end
   end

   // State register
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
         st_ff <= SH_RST;
      else
         st_ff <= nxt_st;
   end

   assign lk.line = st_ff.line;
   assign lk.busy = (st_ff.st != ux_sh_idle);
   assign lk.done = st_ff.done;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   a_start_half: assert property (
      (st_ff.st == ux_sh_armed && lk.rise_tick && !lk.abort)
      |=> (st_ff.st == ux_sh_start && !st_ff.line))
      else $error("Start bit not driven on the next rising tick");

   a_data_count: assert property (
      $rose(st_ff.st == ux_sh_stop)
      |-> $past(st_ff.bit_idx) == `UX_LAST_BASE + {1'b0, st_ff.len})
      else $error("Wrong number of data bits sent");

   a_stop_length: assert property (
      st_ff.done |-> $past(st_ff.clk_cnt) + 6'h01 ==
         (!st_ff.stop_sel ? `UX_STOP_ONE :
          (st_ff.len == 2'h0 ? `UX_STOP_ONEHALF : `UX_STOP_TWO)))
      else $error("Stop period has the wrong length");
endmodule : uartx_shift
`default_nettype wire

// ### verilog/uartx_top.sv
// Transmit control: bus write port, control register, serial out
// Functional notes
// - Break holds serial out low; freed by clear, CTS high, or word end.
// - A word sent during break is invalid; no correction is made.
// - Writing send-request high drives request-to-send low, enables transfer.
// - Control bits 4:3 at 00, 01, 10 give 5, 6, 7 data bits.
// - Bit 2 low: one stop; high: 1.5 for 5-bit words, else two.
// - Holding register captures bus data at the end of the timing pulse.
// - Shifter loads on first falling clock half period plus setup later.
// - Start bit begins half a clock period after the shifter loads.
`timescale 1ns/10ps
`default_nettype none
`include "uartx_consts.svh"
module uartx_top
   import uartx_pkg::*;
#(
   parameter int CLK_DIV = 64
)
(
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_bus_timing_pulse,
   input wire logic i_chip_select_a,
   input wire logic i_chip_select_n,
   input wire logic i_chip_select_b,
   input wire logic i_read_write_n,
   input wire logic i_reg_select,
   input wire logic [7:0] i_bus_data,
   input wire logic i_clear_to_send_n,
   input wire logic i_master_clear_n,
   output logic o_serial_out_line,
   output logic o_request_to_send_n,
   output logic o_holding_empty_flag
);
   // ----------------------------------------------------------------
   // Parameter checks and derived counts
   // ----------------------------------------------------------------
   if (CLK_DIV < 2 || CLK_DIV > 65534 || (CLK_DIV % 2) != 0)
   begin : g_bad_div
      $error("CLK_DIV must be even and within 2..65534");
   end

   localparam logic [15:0] DIV_LAST = 16'(CLK_DIV - 1);
   localparam logic [15:0] DIV_HALF = 16'(CLK_DIV / 2);
   localparam logic [15:0] LOAD_WAIT = 16'(CLK_DIV / 2 + `UX_TC_CYCLES);

   localparam uartx_top_st_t TOP_RST = '{
      s1: 16'hFFFF, s2: 16'hFFFF, s3: 16'hFFFF, pins: 16'hFFFF,
      tpb_prev: 1'b1, cts_prev: 1'b1, qual_ok: 1'b0, wdata: 8'h00,
      wsel: 1'b0, ctrl: `UX_CTRL_RST, hold: 8'h00, hold_full: 1'b0,
      wait_cnt: 16'h0000, div_cnt: 16'h0000, rise: 1'b0, fall: 1'b0,
      load: 1'b0, serial: 1'b1, rts_n: 1'b1, holding_empty_flag: 1'b1};

   uartx_top_st_t st_ff;
   uartx_top_st_t nxt_st;
   logic [15:0] raw_pins;
   logic [15:0] agree;
   logic bus_qual;
   logic wr;
   logic wr_ctrl;
   logic wr_hold;
   logic mclr;
   logic cts_rise;

   uartx_link_if lk ();

   uartx_shift u_shift (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .lk(lk.shift)
   );

   // ----------------------------------------------------------------
   // Pin capture and write decode
   // ----------------------------------------------------------------
   // Pins are asynchronous; a change counts once stages two and three agree
   assign raw_pins = {i_bus_timing_pulse, i_chip_select_a, i_chip_select_n,
      i_chip_select_b, i_read_write_n, i_reg_select, i_clear_to_send_n,
      i_master_clear_n, i_bus_data};
   assign agree = st_ff.s2 ~^ st_ff.s3;

   // Write is the overlap of all selects with the timing pulse
   assign bus_qual = st_ff.pins[`UX_P_CSA] & st_ff.pins[`UX_P_CSB]
      & ~st_ff.pins[`UX_P_CSN] & ~st_ff.pins[`UX_P_RDWR];
   assign wr = st_ff.tpb_prev & ~st_ff.pins[`UX_P_TPB] & st_ff.qual_ok;
   assign wr_ctrl = wr & st_ff.wsel;
   assign wr_hold = wr & ~st_ff.wsel;
   assign mclr = ~st_ff.pins[`UX_P_MCLRN];
   // Clear-to-send going inactive ends a break
   assign cts_rise = ~st_ff.cts_prev & st_ff.pins[`UX_P_CTSN];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.s1 = raw_pins;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      nxt_st.pins = (agree & st_ff.s3) | (~agree & st_ff.pins);
      nxt_st.tpb_prev = st_ff.pins[`UX_P_TPB];
      nxt_st.cts_prev = st_ff.pins[`UX_P_CTSN];

      // Selects must hold for the whole pulse; data sampled while high
      if (st_ff.pins[`UX_P_TPB])
      begin
         nxt_st.qual_ok = st_ff.tpb_prev ? (st_ff.qual_ok & bus_qual)
                                         : bus_qual;
         nxt_st.wdata = st_ff.pins[7:0];
         nxt_st.wsel = st_ff.pins[`UX_P_RSEL];
      end

      // Device clock as rise and fall enables
      nxt_st.rise = (st_ff.div_cnt == 16'h0000);
      nxt_st.fall = (st_ff.div_cnt == DIV_HALF);
      nxt_st.div_cnt = (st_ff.div_cnt == DIV_LAST) ? 16'h0000
                                                   : st_ff.div_cnt + 16'h0001;

      // Control register; a write with send-request set touches only it
      if (wr_ctrl)
      begin
         if (st_ff.wdata[`UX_B_SEND])
            nxt_st.ctrl[`UX_B_SEND] = 1'b1;
         else
            nxt_st.ctrl = st_ff.wdata;
      end
      else if (cts_rise || lk.done)
         nxt_st.ctrl[`UX_B_BREAK] = 1'b0;

      // Shifter load on a falling edge once the setup wait is over
      nxt_st.load = 1'b0;
      if (st_ff.wait_cnt != 16'h0000)
         nxt_st.wait_cnt = st_ff.wait_cnt - 16'h0001;
      if (st_ff.fall && st_ff.wait_cnt == 16'h0000 && st_ff.hold_full
          && !lk.busy && !st_ff.load && st_ff.ctrl[`UX_B_SEND]
          && !st_ff.pins[`UX_P_CTSN])
      begin
         nxt_st.load = 1'b1;
         nxt_st.hold_full = 1'b0;
      end

      // A new write wins over a same-cycle load
      if (wr_hold)
      begin
         nxt_st.hold = st_ff.wdata;
         nxt_st.hold_full = 1'b1;
         // Cancel the load, else the new byte would go out twice
         nxt_st.load = 1'b0;
         nxt_st.wait_cnt = LOAD_WAIT;
      end

      // Master clear drops control and pending data
      if (mclr)
      begin
         nxt_st.ctrl = `UX_CTRL_RST;
         nxt_st.hold_full = 1'b0;
         nxt_st.wait_cnt = 16'h0000;
         nxt_st.load = 1'b0;
      end

      // Break forces the line low; a word under break stays invalid
      nxt_st.serial = lk.line & ~st_ff.ctrl[`UX_B_BREAK];
      nxt_st.rts_n = ~st_ff.ctrl[`UX_B_SEND];
      nxt_st.holding_empty_flag = ~st_ff.hold_full;
   end

   // State register
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
         st_ff <= TOP_RST;
      else
         st_ff <= nxt_st;
   end

   // ----------------------------------------------------------------
   // Shifter link and outputs
   // ----------------------------------------------------------------
   assign lk.load = st_ff.load;
   assign lk.rise_tick = st_ff.rise;
   assign lk.abort = mclr;
   assign lk.data = st_ff.hold;
   assign lk.stop_sel = st_ff.ctrl[`UX_B_STOP];
   assign lk.len_sel = {st_ff.ctrl[`UX_B_LEN_HI], st_ff.ctrl[`UX_B_LEN_LO]};
   assign o_serial_out_line = st_ff.serial;
   assign o_request_to_send_n = st_ff.rts_n;
   assign o_holding_empty_flag = st_ff.holding_empty_flag;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   a_break_low: assert property (
      st_ff.ctrl[`UX_B_BREAK] |=> !o_serial_out_line)
      else $error("Serial out not low during break");

   a_break_release: assert property (
      (st_ff.ctrl[`UX_B_BREAK] && lk.done && !wr_ctrl)
      |=> !st_ff.ctrl[`UX_B_BREAK])
      else $error("Break not released at word end");

   a_break_word: assert property (
      (st_ff.ctrl[`UX_B_BREAK] && !wr_ctrl && !lk.done && !mclr
       && !cts_rise)
      |=> !o_serial_out_line [*2])
      else $error("Line rose while break stays set");

   a_send_rts: assert property (
      (wr_ctrl && st_ff.wdata[`UX_B_SEND] && !mclr)
      |-> ##2 !o_request_to_send_n)
      else $error("Request-to-send not low after send write");

   a_hold_capture: assert property (
      (wr_hold && !mclr) |=> st_ff.hold == $past(st_ff.wdata)
         && st_ff.hold_full ##1 !o_holding_empty_flag)
      else $error("Holding register not loaded on write");

   a_load_timing: assert property (
      st_ff.load |-> $past(st_ff.fall) && $past(st_ff.wait_cnt) == 16'h0000)
      else $error("Shifter loaded before setup or off a falling edge");
endmodule : uartx_top
`default_nettype wire

// ### verif/uartx_line_rx.sv
// Serial receiver standing at the far end of the transmit line
`timescale 1ns/10ps
`default_nettype none
module uartx_line_rx
#(
   parameter int CLK_DIV = 4
)
(
   input wire logic i_ref_clk,
   input wire logic i_line,
   input wire logic [3:0] i_nbits
);
   // Decoded frames; the bench reads and flushes them
   logic [7:0] data_q[$];
   logic stop_q[$];
   time start_q[$];
   logic [7:0] shreg;
   int i;

   // Mid-bit sampling, LSB first; a bit lasts 16 device clocks
   initial
   begin
      forever
      begin
         @(negedge i_line);
         start_q.push_back($time);
         repeat (8 * CLK_DIV) @(posedge i_ref_clk);
         shreg = 8'h00;
         for (i = 0; i < int'(i_nbits); i++)
         begin
            repeat (16 * CLK_DIV) @(posedge i_ref_clk);
            shreg[i] = i_line;
         end
         repeat (16 * CLK_DIV) @(posedge i_ref_clk);
         stop_q.push_back(i_line);
         data_q.push_back(shreg);
         // A line held low by break must rise before a new frame
         if (i_line !== 1'b1)
            @(posedge i_line);
      end
   end
endmodule : uartx_line_rx
`default_nettype wire

// ### verif/uart_tx_control_mode1_test.sv
// Self-checking bench for the transmit control block
`timescale 1ns/10ps
`default_nettype none
`include "uartx_consts.svh"
module uart_tx_control_mode1_test;
   // Small divider keeps frames short: one bit is 64 cycles
   localparam int CLK_DIV = 4;
   localparam int LIMIT = 60000;
   localparam logic [3:0] SEL_GOOD = 4'hA;
   localparam logic [3:0] SEL_IDLE = 4'h5;
   localparam logic [3:0] BAD [4] = '{4'h2, 4'hE, 4'h8, 4'hB};

   logic clk, resetn, bus_timing_pulse, cs_a, cs_n, cs_b, rw_n, rsel, cts_n, mclr_n;
   logic [7:0] bus_d;
   logic ser, rts_n, holding_empty_flag;
   logic [3:0] rx_bits;
   int n_errors, tests_run, cyc;
   time t_wr;

   uartx_top #(.CLK_DIV(CLK_DIV)) i_dut (
      .i_ref_clk(clk),
      .i_resetn(resetn),
      .i_bus_timing_pulse(bus_timing_pulse),
      .i_chip_select_a(cs_a),
      .i_chip_select_n(cs_n),
      .i_chip_select_b(cs_b),
      .i_read_write_n(rw_n),
      .i_reg_select(rsel),
      .i_bus_data(bus_d),
      .i_clear_to_send_n(cts_n),
      .i_master_clear_n(mclr_n),
      .o_serial_out_line(ser),
      .o_request_to_send_n(rts_n),
      .o_holding_empty_flag(holding_empty_flag)
   );

   uartx_line_rx #(.CLK_DIV(CLK_DIV)) i_rx (
      .i_ref_clk(clk),
      .i_line(ser),
      .i_nbits(rx_bits)
   );

   // Clock at 250 MHz
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Hang guard, well above the longest expected run
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         n_errors++;
         tally_and_finish();
      end
   end

   // Comparisons
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic check_rng(input int v, input int lo, input int hi);
      tests_run++;
      if (v < lo || v > hi)
      begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h..%h", $time, v, lo, hi);
      end
   endtask : check_rng

   // Output picker: 0 serial line, 1 send request, 2 holding empty
   function automatic logic probe(input int s);
      case (s)
         0: return ser;
         1: return rts_n;
         default: return holding_empty_flag;
      endcase
   endfunction : probe

   // Bounded wait for an output level, then compare it
   task automatic wait_sig(input int s, input logic v, input int max);
      int k;
      k = 0;
      while (probe(s) !== v && k < max)
      begin
         @(negedge clk);
         k++;
      end
      check(32'(probe(s)), 32'(v));
   endtask : wait_sig

   // Pins held five cycles each so the three-flop sync settles
   task automatic bus_wr(input logic rs, input logic [7:0] d,
                         input logic [3:0] sel);
      @(negedge clk);
      {cs_a, cs_n, cs_b, rw_n} = sel;
      rsel = rs;
      bus_d = d;
      bus_timing_pulse = 1'b1;
      repeat (5) @(negedge clk);
      bus_timing_pulse = 1'b0;
      t_wr = $time;
      repeat (5) @(negedge clk);
      {cs_a, cs_n, cs_b, rw_n} = SEL_IDLE;
   endtask : bus_wr

   // Cycles from one start bit to the next when words run back to back
   function automatic int frame_cyc(input int nb, input logic two);
      int stop;
      stop = !two ? 16 : (nb == 5 ? 24 : 32);
      return ((1 + nb) * 16 + stop) * CLK_DIV;
   endfunction : frame_cyc

   task automatic flush();
      i_rx.data_q.delete();
      i_rx.stop_q.delete();
      i_rx.start_q.delete();
   endtask : flush

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   // Main sequence
   initial
   begin
      int k, cfg, nb;
      time t0;
      logic [7:0] d0, d1, msk;
      logic [1:0] len;
      logic two;
      resetn = 1'b0;
      bus_timing_pulse = 1'b0;
      {cs_a, cs_n, cs_b, rw_n} = SEL_IDLE;
      rsel = 1'b0;
      bus_d = 8'h00;
      cts_n = 1'b0;
      mclr_n = 1'b1;
      rx_bits = 4'h5;
      void'($urandom(83));
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      repeat (6) @(negedge clk);
      check(32'({ser, rts_n, holding_empty_flag}), 32'h7);
      // Every length and stop setting, then random settings
      for (int i = 0; i < 12; i++)
      begin
         cfg = (i < 8) ? i : int'($urandom_range(7));
         len = 2'(cfg >> 1);
         two = cfg[0];
         nb = 5 + int'(len);
         rx_bits = 4'(nb);
         msk = 8'((1 << nb) - 1);
         bus_wr(1'b1, {3'h0, len, two, 2'h0}, SEL_GOOD);
         bus_wr(1'b1, 8'h80, SEL_GOOD);
         wait_sig(1, 1'b0, 20);
         flush();
         d0 = 8'($urandom);
         d1 = two ? 8'hFF : 8'h00;
         bus_wr(1'b0, d0, SEL_GOOD);
         t0 = t_wr;
         wait_sig(2, 1'b0, 20);
         wait_sig(2, 1'b1, 200);
         bus_wr(1'b0, d1, SEL_GOOD);
         wait_sig(2, 1'b0, 20);
         wait_sig(2, 1'b1, 2000);
         k = 0;
         while (i_rx.data_q.size() < 2 && k < 3000)
         begin
            @(negedge clk);
            k++;
         end
         check(32'(i_rx.data_q.size()), 32'h2);
         if (i_rx.data_q.size() == 2)
         begin
            check(32'(i_rx.data_q[0]), 32'(d0 & msk));
            check(32'(i_rx.data_q[1]), 32'(d1 & msk));
            check(32'({i_rx.stop_q[0], i_rx.stop_q[1]}), 32'h3);
            check_rng(int'((i_rx.start_q[0] - t0) / 4),
               `UX_TC_CYCLES + CLK_DIV / 2,
               `UX_TC_CYCLES + 3 * CLK_DIV + 12);
            check_rng(int'((i_rx.start_q[1] - i_rx.start_q[0]) / 4),
               frame_cyc(nb, two), frame_cyc(nb, two) + 14);
         end
      end
      // Writes with a wrong select or a read are ignored
      for (int j = 0; j < 4; j++)
         bus_wr(1'b1, 8'h00, BAD[j]);
      bus_wr(1'b0, 8'h55, BAD[0]);
      repeat (10) @(negedge clk);
      check(32'({rts_n, holding_empty_flag}), 32'h1);
      // Break, released by clear-to-send going high
      bus_wr(1'b1, 8'h40, SEL_GOOD);
      bus_wr(1'b1, 8'h80, SEL_GOOD);
      wait_sig(0, 1'b0, 20);
      repeat (100) @(negedge clk);
      check(32'(ser), 32'h0);
      cts_n = 1'b1;
      wait_sig(0, 1'b1, 20);
      cts_n = 1'b0;
      // Break, released by master clear, which also drops send request
      bus_wr(1'b1, 8'h40, SEL_GOOD);
      bus_wr(1'b1, 8'h80, SEL_GOOD);
      wait_sig(0, 1'b0, 20);
      mclr_n = 1'b0;
      wait_sig(0, 1'b1, 20);
      wait_sig(1, 1'b1, 20);
      repeat (6) @(negedge clk);
      mclr_n = 1'b1;
      repeat (6) @(negedge clk);
      // Word sent under break: line stays low until the word ends
      bus_wr(1'b1, 8'h40, SEL_GOOD);
      bus_wr(1'b1, 8'h80, SEL_GOOD);
      wait_sig(0, 1'b0, 20);
      bus_wr(1'b0, 8'hFF, SEL_GOOD);
      t0 = t_wr;
      wait_sig(0, 1'b1, 1200);
      check_rng(int'(($time - t0) / 4), frame_cyc(5, 1'b0),
         frame_cyc(5, 1'b0) + 200);
      repeat (200) @(negedge clk);
      check(32'(ser), 32'h1);
      tally_and_finish();
   end
endmodule : uart_tx_control_mode1_test
`default_nettype wire
